// ==== shared/mpwob_consts.vh ====
// constants for the multi pulse width output bank
`ifndef MPWOB_CONSTS_VH
`define MPWOB_CONSTS_VH

// ==========================================================
// register map (8-bit word index)
`define MPWOB_ADDR_W 8
`define MPWOB_DATA_W 8
`define MPWOB_REG_LATCH0 8'h0A
`define MPWOB_REG_LATCH7 8'h11
`define MPWOB_REG_FINE 8'h12
`define MPWOB_REG_COARSE 8'h13
`define MPWOB_REG_LOW_EN 8'h15
`define MPWOB_REG_HIGH_EN 8'h16
`define MPWOB_REG_LEVEL 8'h17
`define MPWOB_REG_STATUS 8'h18

// ==========================================================
// field positions
`define MPWOB_HIGH_EN_BIT 0
`define MPWOB_LVL_SEVEN_BIT 0
`define MPWOB_LVL_SIX_BIT 1
`define MPWOB_LVL_HIGH_BIT 2

// ==========================================================
// reset values
`define MPWOB_RST_LATCH 8'h00
`define MPWOB_RST_FINE 7'h7F
`define MPWOB_RST_COARSE 7'h00
`define MPWOB_RST_EN 8'h00
`define MPWOB_RST_LEVEL 3'h0

// ==========================================================
// timing
`define MPWOB_DIV 3
`define MPWOB_SIX_PERIOD 64
`define MPWOB_SEVEN_PERIOD 128

`endif

// ==== hdl/mpwob_div3.v ====
// divide-by-three enable pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "mpwob_consts.vh"

module mpwob_div3 (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // enable pulse
    output reg tick
);
    reg [1:0] cnt;

    // ==========================================================
    // divider
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 2'h0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt == 2'h0);
            if (cnt == (`MPWOB_DIV - 1)) begin
                cnt <= 2'h0;
            end else begin
                cnt <= cnt + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== hdl/mpwob_fine_sel.v ====
// fine pulse subperiod selector
`timescale 1ns/1ps
`default_nettype none

module mpwob_fine_sel (
    // inputs
    input wire [6:0] fine_latch,
    input wire [6:0] subperiod,
    // result
    output reg select
);
    integer k;

    // ==========================================================
    // a zero in bit k picks subperiods that are odd multiples of 2^(6-k)
    always @* begin
        select = 1'b0;
        for (k = 0; k < 7; k = k + 1) begin
            if (!fine_latch[k] && ((subperiod & ((7'h01 << (6 - k)) - 7'h01)) == 7'h00)
                && subperiod[6 - k]) begin
                select = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== hdl/mpwob_top.v ====
// nine channel pulse width output bank with shared port pins
// Function
// - low-res enable picks pulse or port line
// - two level bits set low-res polarity
// - eight consecutive latches set low-res duty
// - low-res clock is crystal over three
// - six-bit channels repeat every 192 crystals
// - seven-bit channels repeat every 384 crystals
// - high-res enable picks pulse or port
// - fine and coarse latches at adjacent registers
// - writing either latch loads working register
// - upper bits coarse, lower bits fine select
// - high-res output is coarse OR fine
// - own level bit sets high-res polarity
// - 14-bit counter, 384 subperiod, 49152 cycle
// - coarse low for latch plus one clocks
// - fine pulse one clock at subperiod start
// - zero bits select, selections are unioned
// - bits 3..6 select finer subperiod sets
// - all ones latch adds no fine pulses
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "mpwob_consts.vh"

module mpwob_top (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // port line values from the port logic
    input wire [7:0] shared_port_lines_low,
    input wire shared_port_line_high,
    // output pins
    output reg [7:0] low_res_pulse_outputs,
    output reg high_res_pulse_output
);
    // ==========================================================
    // registers
    reg [7:0] duty_latch [0:7];
    reg [6:0] fine_pulse_select_latch;
    reg [6:0] coarse_width_latch;
    reg [13:0] working_width_register;
    reg [7:0] low_res_channel_enable;
    reg high_res_channel_enable;
    reg seven_bit_level_select;
    reg six_bit_level_select;
    reg high_res_level_select;

    // ==========================================================
    // timebase
    wire tick;
    reg [6:0] low_cnt;
    reg [13:0] hi_cnt;

    mpwob_div3 u_div (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick)
    );

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= 7'h00;
            hi_cnt <= 14'h0000;
        end else if (tick) begin
            low_cnt <= low_cnt + 7'h01;
            hi_cnt <= hi_cnt + 14'h0001;
        end
    end

    // ==========================================================
    // register writes
    wire wr_latch = reg_wr && (reg_addr >= `MPWOB_REG_LATCH0) && (reg_addr <= `MPWOB_REG_LATCH7);
    wire [2:0] latch_idx = reg_addr[2:0] - 3'h2;
    integer i;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 8; i = i + 1) begin
                duty_latch[i] <= `MPWOB_RST_LATCH;
            end
            fine_pulse_select_latch <= `MPWOB_RST_FINE;
            coarse_width_latch <= `MPWOB_RST_COARSE;
            working_width_register <= {`MPWOB_RST_COARSE, `MPWOB_RST_FINE};
            low_res_channel_enable <= `MPWOB_RST_EN;
            high_res_channel_enable <= 1'b0;
            seven_bit_level_select <= 1'b0;
            six_bit_level_select <= 1'b0;
            high_res_level_select <= 1'b0;
        end else if (reg_wr) begin
            if (wr_latch) begin
                duty_latch[latch_idx] <= reg_wdata;
            end
            case (reg_addr)
                `MPWOB_REG_FINE: begin
                    fine_pulse_select_latch <= reg_wdata[6:0];
                    working_width_register <= {coarse_width_latch, reg_wdata[6:0]};
                end
                `MPWOB_REG_COARSE: begin
                    coarse_width_latch <= reg_wdata[6:0];
                    working_width_register <= {reg_wdata[6:0], fine_pulse_select_latch};
                end
                `MPWOB_REG_LOW_EN: begin
                    low_res_channel_enable <= reg_wdata;
                end
                `MPWOB_REG_HIGH_EN: begin
                    high_res_channel_enable <= reg_wdata[`MPWOB_HIGH_EN_BIT];
                end
                `MPWOB_REG_LEVEL: begin
                    seven_bit_level_select <= reg_wdata[`MPWOB_LVL_SEVEN_BIT];
                    six_bit_level_select <= reg_wdata[`MPWOB_LVL_SIX_BIT];
                    high_res_level_select <= reg_wdata[`MPWOB_LVL_HIGH_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // register reads, data valid the cycle after the strobe
    reg [7:0] next_rdata;

    always @* begin
        next_rdata = 8'h00;
        if (wr_latch || ((reg_addr >= `MPWOB_REG_LATCH0) && (reg_addr <= `MPWOB_REG_LATCH7))) begin
            next_rdata = duty_latch[latch_idx];
        end
        case (reg_addr)
            `MPWOB_REG_FINE: next_rdata = {1'b0, fine_pulse_select_latch};
            `MPWOB_REG_COARSE: next_rdata = {1'b0, coarse_width_latch};
            `MPWOB_REG_LOW_EN: next_rdata = low_res_channel_enable;
            `MPWOB_REG_HIGH_EN: next_rdata = {7'h00, high_res_channel_enable};
            `MPWOB_REG_LEVEL: next_rdata = {5'h00, high_res_level_select,
                                            six_bit_level_select, seven_bit_level_select};
            // live state: subperiod index and the high-res pin level
            `MPWOB_REG_STATUS: next_rdata = {high_res_pulse_output, hi_cnt[13:7]};
            default: begin
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // low resolution channels: 0..3 seven bit, 4..7 six bit
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_low
            // genvar compare is 32 bits wide, so narrow it to one bit on purpose
            wire six = (g >= 4) ? 1'b1 : 1'b0;
            wire [6:0] pos = six ? {1'b0, low_cnt[5:0]} : low_cnt;
            wire [6:0] duty = six ? {1'b0, duty_latch[g][5:0]} : duty_latch[g][6:0];
            wire raw = (pos < duty);
            wire lvl = six ? six_bit_level_select : seven_bit_level_select;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    low_res_pulse_outputs[g] <= 1'b0;
                end else if (low_res_channel_enable[g]) begin
                    low_res_pulse_outputs[g] <= raw ^ lvl;
                end else begin
                    low_res_pulse_outputs[g] <= shared_port_lines_low[g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // high resolution channel
    wire [6:0] position = hi_cnt[6:0];
    wire [6:0] subperiod = hi_cnt[13:7];
    wire fine_sel;

    mpwob_fine_sel u_fine (
        .fine_latch(working_width_register[6:0]),
        .subperiod(subperiod),
        .select(fine_sel)
    );

    // coarse high from position latch+1 until the subperiod ends
    wire coarse_out = (position > working_width_register[13:7]);
    wire fine_out = fine_sel && (position == 7'h00);
    wire mixed = coarse_out | fine_out;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            high_res_pulse_output <= 1'b0;
        end else if (high_res_channel_enable) begin
            high_res_pulse_output <= mixed ^ high_res_level_select;
        end else begin
            high_res_pulse_output <= shared_port_line_high;
        end
    end
endmodule
`default_nettype wire

// ==== test/mpwob_rc_net.sv ====
// behavioural integrator standing in for the RC filter on one pin
`timescale 1ns/1ps
`default_nettype none
module mpwob_rc_net (
    // clock and clear
    input wire logic clk,
    input wire logic clr,
    // filtered pin and charge
    input wire logic pin,
    output logic [16:0] acc
);
    // charge kept as a count of high clocks, so the mean is phase independent
    always @(posedge clk) begin
        acc <= clr ? 17'h00000 : acc + {16'h0000, pin};
    end
endmodule
`default_nettype wire

// ==== test/mpwob_top_chk.sv ====
// port checker for the pulse width output bank
`timescale 1ns/1ps
`default_nettype none
module mpwob_top_chk (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // pins
    input wire [7:0] shared_port_lines_low,
    input wire shared_port_line_high,
    input wire [7:0] low_res_pulse_outputs,
    input wire high_res_pulse_output
);
    logic [7:0] en_sh;
    logic hen_sh;
    logic [8:0] quiet;
    logic [1:0] up;
    wire steady = quiet == 9'h1FF;
    // ==========================================================
    // shadows; period and edge checks on pins wait long after the last write
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_sh <= 8'h00;
            hen_sh <= 1'b0;
            quiet <= 9'h000;
            up <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == 8'h15) en_sh <= reg_wdata;
            if (reg_wr && reg_addr == 8'h16) hen_sh <= reg_wdata[0];
            quiet <= reg_wr ? 9'h000 : (steady ? quiet : quiet + 9'h001);
            up <= (up == 2'h3) ? up : up + 2'h1;
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    unmapped_zero_a: assert property ($past(reg_rd && reg_addr < 8'h0A) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    enable_read_a: assert property ($past(reg_rd && reg_addr == 8'h15) |-> reg_rdata == $past(en_sh))
        else $error("enable read back wrong");
    status_pin_a: assert property ($past(reg_rd && reg_addr == 8'h18) |->
        reg_rdata[7] == $past(high_res_pulse_output))
        else $error("status pin bit wrong");
    port_pass_a: assert property (up == 2'h3 |->
        ((low_res_pulse_outputs ^ $past(shared_port_lines_low)) & ~$past(en_sh)) == 8'h00)
        else $error("disabled pin not port line");
    high_pass_a: assert property (up == 2'h3 && !$past(hen_sh) |->
        high_res_pulse_output == $past(shared_port_line_high))
        else $error("disabled high pin not port line");
    six_period_a: assert property (steady && en_sh[4] |->
        low_res_pulse_outputs[4] == $past(low_res_pulse_outputs[4], 192))
        else $error("six bit period wrong");
    seven_period_a: assert property (steady && en_sh[0] |->
        low_res_pulse_outputs[0] == $past(low_res_pulse_outputs[0], 384))
        else $error("seven bit period wrong");
    tick_aligned_a: assert property (steady && hen_sh && $changed(high_res_pulse_output) |->
        $past(high_res_pulse_output, 1) == $past(high_res_pulse_output, 3))
        else $error("high pin edge off divided clock");
    cover property (steady && en_sh[0] && $rose(low_res_pulse_outputs[0]));
    cover property (steady && hen_sh && $rose(high_res_pulse_output));
    cover property ($past(reg_rd && reg_addr == 8'h15));
endmodule
bind mpwob_top mpwob_top_chk chk (.*);
`default_nettype wire

// ==== test/mpwob_top_tb.sv ====
// self-checking bench for the pulse width output bank
`timescale 1ns/1ps
`default_nettype none
module mpwob_top_tb;
    logic clk, rst_n, reg_wr, reg_rd, hi_in, hi_out, clr, pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, lo_in, lo_out, v8;
    logic [16:0] acc, v17;
    logic [6:0] f, h;
    int num_errors, tests_run, sel, lv, lat;
    logic [7:0] ra[4] = '{8'h15, 8'h12, 8'h13, 8'h00};
    logic [7:0] rv[4] = '{8'h00, 8'h7F, 8'h00, 8'h00};
    mpwob_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .shared_port_lines_low(lo_in), .shared_port_line_high(hi_in),
        .low_res_pulse_outputs(lo_out), .high_res_pulse_output(hi_out));
    assign pin = (sel == 8) ? hi_out : lo_out[sel[2:0]];
    mpwob_rc_net rc (.clk(clk), .clr(clr), .pin(pin), .acc(acc));
    // ==========================================================
    // helpers
    task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // high clocks of one pin over n clocks, after the write has landed
    task automatic meas(input int s, input int n, output logic [16:0] v);
        sel = s;
        repeat (4) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n) @(posedge clk);
        #1 v = acc;
    endtask
    function automatic logic [16:0] lo_exp(int ch, int l, int lv);
        int hi;
        hi = (ch < 4) ? 3 * l : 6 * l;
        return 17'(lv[(ch < 4) ? 0 : 1] ? 384 - hi : hi);
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        test_done;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, clr, hi_in} = 5'h01;
        {reg_addr, reg_wdata, lo_in, sel} = '0;
        void'($urandom(64));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ra[i]) begin
            rd(ra[i], v8);
            chk("reset value", 17'(v8), 17'(rv[i]));
        end
        $display("test reset_values done");
        lo_in <= 8'($urandom);
        hi_in <= 1'($urandom);
        repeat (3) @(posedge clk);
        chk("port lines", 17'(lo_out), 17'(lo_in));
        chk("high port line", 17'(hi_out), 17'(hi_in));
        $display("test port_pass done");
        wr(8'h15, 8'hFF);
        for (int ch = 0; ch < 8; ch++) begin
            lat = (ch == 0) ? 127 : (ch == 4) ? 63 : (ch == 5) ? 0 : $urandom % (ch < 4 ? 128 : 64);
            lv = $urandom % 4;
            wr(8'h17, 8'(lv));
            wr(8'h0A + 8'(ch), 8'(lat));
            rd(8'h0A + 8'(ch), v8);
            chk("duty latch", 17'(v8), 17'(lat));
            meas(ch, 384, v17);
            chk("low res duty", v17, lo_exp(ch, lat, lv));
        end
        $display("test low_res done");
        wr(8'h16, 8'h01);
        for (int i = 0; i < 3; i++) begin
            h = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : 7'($urandom);
            wr(8'h13, {1'b0, h});
            rd(8'h13, v8);
            chk("coarse latch", 17'(v8), 17'(h));
            meas(8, 384, v17);
            chk("coarse width", v17, 17'(3 * (127 - h)));
        end
        $display("test coarse done");
        f = 7'($urandom);
        wr(8'h12, {1'b0, f});
        wr(8'h17, 8'h04);
        rd(8'h12, v8);
        chk("fine latch", 17'(v8), 17'(f));
        meas(8, 49152, v17);
        // inverted level; the fine pulses add three clocks per selected subperiod
        chk("full cycle", v17, 17'(49152 - 3 * (16383 - {h, f})));
        // live status read; the checker judges the pin bit
        rd(8'h18, v8);
        $display("test full_cycle done");
        test_done;
    end
endmodule
`default_nettype wire
